// ### verilog/rio_params.svh
`ifndef RIO_PARAMS_SVH
`define RIO_PARAMS_SVH

// register byte addresses; channel block is 0x40 + 16*ch, words 0..2 iface, 3 csr
`define ADDR_CMD        8'h00
`define ADDR_DATA       8'h04
`define ADDR_CH_SEL     4'h4    // upper address nibble of channel 0's block
`define CH_CSR_WORD     2'h3

// command word fields
`define CMD_IGNORE_BIT  31
`define CMD_WRITE_BIT   15
`define CMD_ROM_BIT     14
`define CMD_REQ_BIT     13
`define CMD_CYCLE_BIT   12
`define CMD_IDLE        16'h0000
`define TYPE_STOP       8'h08
`define TYPE_START_NORM 8'h09
`define TYPE_START_SET  8'h0F

// read-only local parameters
`define PARAM_ID        8'h5A
`define PARAM_PORT_W    8'h08
`define PARAM_REV_MAJ   8'h01
`define PARAM_REV_MIN   8'h00
`define PARAM_GP_NONE   8'h00
`define PARAM_VARIANT   8'h3C
`define PARAM_CH_COUNT  8'h08

// transfer timeout; one engine timer covers all channels of a command
`define CLK_PERIOD_NS   10
`define XFER_TMO_NS     100000

`endif

// ### verilog/rio_pkg.sv
package rio_pkg;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef enum logic [1:0] {
        OP_START_NEW,
        OP_START_KEEP,
        OP_SETUP,
        OP_XFER
    } link_op_t;

    typedef struct packed {
        logic [7:0] req;
        logic [7:0] halt;
        logic       purge;
        link_op_t   op;
    } link_cmd_t;

    typedef struct packed {
        logic [2:0][31:0] words;
        logic [7:0]       local_flt;
        logic [7:0]       remote_flt;
    } ch_rx_t;

    typedef enum logic {
        ST_IDLE,
        ST_WAIT
    } eng_state_t;

endpackage : rio_pkg

// ### verilog/rio_cmd_engine.sv
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`include "rio_params.svh"

module rio_cmd_engine #(
    parameter int TMO_CYC = `XFER_TMO_NS / `CLK_PERIOD_NS
) (
    input  logic                          i_ref_clk,
    input  logic                          i_rst_n,
    input  rio_pkg::bus_req_t             i_bus,
    output logic [31:0]                   o_rdata,
    output rio_pkg::link_cmd_t            o_link_cmd,
    output logic [7:0][7:0]               o_link_mode,
    output logic [7:0][2:0][31:0]         o_link_tx,
    output logic [7:0]                    o_chatter,
    input  logic [7:0]                    i_link_done,
    input  logic [7:0]                    i_link_fail,
    input  rio_pkg::ch_rx_t [7:0]         i_link_rx
);

    localparam logic [13:0] TMO_LIM = 14'(TMO_CYC);

    rio_pkg::eng_state_t       state_reg;
    rio_pkg::link_op_t         kind_reg;
    logic [15:0]               cmd_reg;
    logic [7:0]                data_reg;
    logic [7:0]                pend_reg;
    logic [7:0]                fail_reg;
    logic [7:0]                mask_reg;
    logic [13:0]               timer_reg;
    logic [7:0]                running_reg;
    logic [7:0]                chatter_reg;
    logic [7:0]                commerr_reg;
    logic [7:0][2:0][31:0]     in_reg;
    logic [7:0][2:0][31:0]     out_reg;
    logic [7:0][7:0]           mode_reg;
    logic [7:0][7:0]           lflt_reg;
    logic [7:0][7:0]           rflt_reg;
    logic [31:0]               rdata_reg;
    rio_pkg::link_cmd_t        link_reg;

    logic                      cmd_wr;
    logic                      cmd_accept;
    logic                      exec;
    logic                      fin;
    logic [7:0]                ctype;
    logic [7:0]                cmask;
    logic                      is_start;
    logic                      is_stop;
    logic                      halt_all;
    logic [7:0]                halt_mask;
    logic [3:0]                ch_blk;
    logic [2:0]                ch_sel;
    logic                      ch_hit;

    // stop-all is the one command allowed over a busy engine
    function automatic logic is_stop_all(input logic [15:0] c);
        return c == {`TYPE_STOP, 8'h00};
    endfunction : is_stop_all

    function automatic logic [7:0] param_of(input logic [15:0] c);
        logic [7:0] v;
        v = 8'h00;
        if (c[7:3] == 5'h00) begin
            unique case (c[2:0])
                3'h0: v = `PARAM_ID;
                3'h1: v = `PARAM_PORT_W;
                3'h2: v = `PARAM_REV_MAJ;
                3'h3: v = `PARAM_REV_MIN;
                3'h4: v = `PARAM_GP_NONE;
                3'h5: v = `PARAM_GP_NONE;
                3'h6: v = `PARAM_VARIANT;
                3'h7: v = `PARAM_CH_COUNT;
            endcase
        end
        return v;
    endfunction : param_of

    // command decode and completion
    // decode fields
    always_comb begin
        cmd_wr     = i_bus.wr && (i_bus.addr == `ADDR_CMD)
                     && !i_bus.wdata[`CMD_IGNORE_BIT];
        cmd_accept = cmd_wr && (cmd_reg == `CMD_IDLE
                     || is_stop_all(i_bus.wdata[15:0]));
        exec       = (state_reg == rio_pkg::ST_IDLE) && (cmd_reg != `CMD_IDLE);
        fin        = (state_reg == rio_pkg::ST_WAIT) && (pend_reg == 8'h00);
        ctype      = cmd_reg[15:8];
        cmask      = cmd_reg[7:0];
        is_start   = (ctype == `TYPE_START_NORM) || (ctype == `TYPE_START_SET);
        is_stop    = (ctype == `TYPE_STOP);
        halt_all   = exec && (cmd_reg[`CMD_ROM_BIT] || (is_stop && cmask == 8'h00));
        halt_mask  = halt_all ? 8'hFF : ((exec && is_stop) ? cmask : 8'h00);
        // blocks 0x40..0xbf; anything below or above wraps past bit 3 and misses
        ch_blk     = i_bus.addr[7:4] - `ADDR_CH_SEL;
        ch_sel     = ch_blk[2:0];
        ch_hit     = !ch_blk[3];
    end

    // command register; an accepted write never loses to the completion clear
    // ignore flag
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cmd_reg <= `CMD_IDLE;
        end else if (cmd_accept) begin
            cmd_reg <= i_bus.wdata[15:0];
        end else if (fin || (exec && !(is_start || cmd_reg[`CMD_CYCLE_BIT]))) begin
            cmd_reg <= `CMD_IDLE;
        end
    end

    // engine sequencing, timeout and fail collection
    // wait all or timeout
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state_reg <= rio_pkg::ST_IDLE;
            kind_reg  <= rio_pkg::OP_XFER;
            pend_reg  <= 8'h00;
            fail_reg  <= 8'h00;
            mask_reg  <= 8'h00;
            timer_reg <= 14'h0000;
        end else if (state_reg == rio_pkg::ST_WAIT) begin
            timer_reg <= timer_reg + 14'h0001;
            if (cmd_accept || fin) begin
                state_reg <= rio_pkg::ST_IDLE;
                pend_reg  <= 8'h00;
            end else if (timer_reg >= TMO_LIM - 14'h0001) begin
                fail_reg <= fail_reg | pend_reg;
                pend_reg <= 8'h00;
            end else begin
                fail_reg <= fail_reg | (pend_reg & i_link_done & i_link_fail);
                pend_reg <= pend_reg & ~i_link_done;
            end
        end else if (exec && (is_start || cmd_reg[`CMD_CYCLE_BIT])) begin
            state_reg <= rio_pkg::ST_WAIT;
            pend_reg  <= cmask;
            mask_reg  <= cmask;
            fail_reg  <= 8'h00;
            timer_reg <= 14'h0000;
            if (!is_start) begin
                kind_reg <= rio_pkg::OP_XFER;
            end else if (ctype == `TYPE_START_SET) begin
                kind_reg <= rio_pkg::OP_SETUP;
            end else begin
                kind_reg <= (running_reg == 8'h00) ? rio_pkg::OP_START_NEW
                                                   : rio_pkg::OP_START_KEEP;
            end
        end
    end

    // data register: host load, local read, result masks
    // 8-bit data
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            data_reg <= 8'h00;
        end else if (fin) begin
            data_reg <= fail_reg;
        end else if (exec && cmd_reg[`CMD_REQ_BIT] && !cmd_reg[`CMD_WRITE_BIT]) begin
            data_reg <= param_of(cmd_reg);
        end else if (i_bus.wr && i_bus.addr == `ADDR_DATA) begin
            data_reg <= i_bus.wdata[7:0];
        end
    end

    // channel run state and keepalive; parameters are read-only so local writes
    // complete without storing anything
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            running_reg <= 8'h00;
            chatter_reg <= 8'h00;
            commerr_reg <= 8'h00;
        end else if (halt_mask != 8'h00) begin
            running_reg <= running_reg & ~halt_mask;
            chatter_reg <= chatter_reg & ~halt_mask;
            commerr_reg <= commerr_reg & ~halt_mask;
        end else if (exec && cmd_reg[`CMD_CYCLE_BIT] && !is_start) begin
            chatter_reg <= 8'h00;
        end else if (fin) begin
            commerr_reg <= (commerr_reg & ~mask_reg) | fail_reg;
            if (kind_reg != rio_pkg::OP_XFER) begin
                running_reg <= running_reg | (mask_reg & ~fail_reg);
            end
            if (kind_reg == rio_pkg::OP_START_NEW || kind_reg == rio_pkg::OP_START_KEEP) begin
                chatter_reg <= chatter_reg | (mask_reg & ~fail_reg);
            end
        end
    end

    // per-channel interface and status registers
    // separate in and out
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            in_reg   <= '0;
            out_reg  <= '0;
            mode_reg <= '0;
            lflt_reg <= '0;
            rflt_reg <= '0;
        end else begin
            for (int c = 0; c < 8; c++) begin
                if (state_reg == rio_pkg::ST_WAIT && pend_reg[c] && i_link_done[c]) begin
                    in_reg[c]   <= i_link_rx[c].words;
                    rflt_reg[c] <= i_link_rx[c].remote_flt;
                end else if (halt_all) begin
                    in_reg[c]   <= '0;
                    rflt_reg[c] <= 8'h00;
                end
                lflt_reg[c] <= (halt_mask[c] ? 8'h00 : lflt_reg[c])
                    | ((pend_reg[c] && i_link_done[c]) ? i_link_rx[c].local_flt : 8'h00);
                if (i_bus.wr && ch_hit && ch_sel == 3'(c)) begin
                    if (i_bus.addr[3:2] == `CH_CSR_WORD) begin
                        mode_reg[c] <= i_bus.wdata[31:24];
                    end else begin
                        out_reg[c][i_bus.addr[3:2]] <= i_bus.wdata;
                    end
                end
            end
        end
    end

    // link requests: one-cycle pulses beside a held op code
    // per-channel mask
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            link_reg <= '{req: 8'h00, halt: 8'h00, purge: 1'b0, op: rio_pkg::OP_XFER};
        end else begin
            link_reg.req   <= (exec && (is_start || cmd_reg[`CMD_CYCLE_BIT])) ? cmask : 8'h00;
            link_reg.halt  <= halt_mask;
            link_reg.purge <= halt_all;
            if (exec && is_start) begin
                link_reg.op <= (ctype == `TYPE_START_SET) ? rio_pkg::OP_SETUP
                             : (running_reg == 8'h00) ? rio_pkg::OP_START_NEW
                             : rio_pkg::OP_START_KEEP;
            end else if (exec && cmd_reg[`CMD_CYCLE_BIT]) begin
                link_reg.op <= rio_pkg::OP_XFER;
            end
        end
    end

    // read port; unmapped addresses and idle cycles read zero
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (!i_bus.rd) begin
            rdata_reg <= 32'h0000_0000;
        end else if (i_bus.addr == `ADDR_CMD) begin
            rdata_reg <= {16'h0000, cmd_reg};
        end else if (i_bus.addr == `ADDR_DATA) begin
            rdata_reg <= {24'h00_0000, data_reg};
        end else if (ch_hit && i_bus.addr[3:2] == `CH_CSR_WORD) begin
            rdata_reg <= {rflt_reg[ch_sel], 8'h00,
                          !running_reg[ch_sel], 1'b0, commerr_reg[ch_sel], 5'h00,
                          lflt_reg[ch_sel]};
        end else if (ch_hit) begin
            rdata_reg <= in_reg[ch_sel][i_bus.addr[3:2]];
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign o_rdata     = rdata_reg;
    assign o_link_cmd  = link_reg;
    assign o_link_mode = mode_reg;
    assign o_link_tx   = out_reg;
    assign o_chatter   = chatter_reg;

    // checks on the engine's own behaviour
    chk_ignore_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_bus.wr && i_bus.addr == `ADDR_CMD && i_bus.wdata[31] && cmd_reg == 16'h0000
         && state_reg == rio_pkg::ST_IDLE) |=> cmd_reg == 16'h0000)
        else $error("ignored command write changed the command register");

    chk_reset_idle: assert property (@(posedge i_ref_clk)
        !i_rst_n |=> cmd_reg == 16'h0000 && state_reg == rio_pkg::ST_IDLE)
        else $error("command register not zero after reset");

    chk_cmd_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (state_reg == rio_pkg::ST_WAIT && pend_reg != 8'h00 && !cmd_accept)
        |=> cmd_reg == $past(cmd_reg))
        else $error("busy command did not read back");

    chk_done_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (fin && !cmd_accept) |=> cmd_reg == 16'h0000 ##1 data_reg == $past(data_reg))
        else $error("completion did not clear command");

    chk_result_mask: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        fin |=> data_reg == $past(fail_reg))
        else $error("result mask not in data register");

    chk_req_mask: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (exec && is_start) |=> o_link_cmd.req == $past(cmask) ##1 o_link_cmd.req == 8'h00)
        else $error("start request mask wrong");

    chk_stop_masked: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (exec && is_stop && cmask != 8'h00)
        |=> (running_reg & $past(cmask)) == 8'h00 && o_link_cmd.purge == 1'b0)
        else $error("individual stop misbehaved");

    chk_xfer_bound: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (state_reg == rio_pkg::ST_WAIT) |-> timer_reg <= TMO_LIM)
        else $error("transfer wait exceeded timeout");

    chk_chatter_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (exec && cmd_reg[12] && !is_start && halt_mask == 8'h00) |=> o_chatter == 8'h00)
        else $error("keepalive not ended by transfer cycle");

    chk_local_read: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (exec && cmd_reg == 16'h2001) |=> data_reg == 8'h08)
        else $error("port width parameter wrong");

endmodule : rio_cmd_engine

// ### verif/rio_link_agent.sv
`timescale 1ns/1ps

module rio_link_agent (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_n,
    input  wire rio_pkg::link_cmd_t    i_cmd,
    input  wire logic [7:0]            i_fail_mask,
    input  wire logic [7:0]            i_mute_mask,
    input  wire logic [3:0]            i_dly,
    output logic [7:0]                 o_done,
    output logic [7:0]                 o_fail,
    output rio_pkg::ch_rx_t [7:0]      o_rx
);
    int          cnt [8];
    logic [31:0] tick;

    initial begin
        o_done = '0;
        o_fail = '0;
        tick   = 32'h0000_0000;
    end

    // remote cards answer after a settable delay; muted ones never answer
    // probe and transfer
    always @(posedge i_ref_clk) begin
        tick <= tick + 32'h0000_0001;
        for (int c = 0; c < 8; c++) begin
            o_done[c] <= 1'b0;
            o_fail[c] <= 1'b0;
            // idle lines wander so stale data never looks valid
            o_rx[c]   <= {tick, ~tick, tick, tick[7:0], tick[15:8]};
            if (!i_rst_n) begin
                cnt[c] <= 0;
            end else if (i_cmd.req[c] && !i_mute_mask[c]) begin
                cnt[c] <= int'(i_dly);
            end else if (cnt[c] > 0) begin
                cnt[c] <= cnt[c] - 1;
                if (cnt[c] == 1) begin
                    o_done[c] <= 1'b1;
                    o_fail[c] <= i_fail_mask[c];
                    // a failed channel also reports a timeout in its local fault byte
                    o_rx[c]   <= {{3{32'ha500_0000 | 32'(c)}},
                                  (i_fail_mask[c] ? 8'h08 : 8'h00), 8'h00};
                end
            end
        end
    end
endmodule : rio_link_agent

// ### verif/remote_io_link_command_engine_bench.sv
`timescale 1ns/1ps
`include "rio_params.svh"

module remote_io_link_command_engine_bench;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    rio_pkg::bus_req_t     bus = '0;
    logic                  chk = 1'b0;
    logic                  chk_d = 1'b0;
    logic [31:0]           o_rdata;
    rio_pkg::link_cmd_t    link_cmd;
    logic [7:0][7:0]       link_mode;
    logic [7:0][2:0][31:0] link_tx;
    logic [7:0]            chatter;
    logic [7:0]            done;
    logic [7:0]            fail;
    rio_pkg::ch_rx_t [7:0] rx;
    logic [7:0]            fail_mask = '0;
    logic [7:0]            mute_mask = '0;
    logic [3:0]            dly = 4'h1;
    logic [31:0]           exp_q[$];
    logic [31:0]           halt_q[$];
    logic [31:0]           req_q[$];
    logic [31:0]           seed = 32'hc985;
    int                    n_errors = 0;
    int                    checks = 0;

    initial begin
        forever #5 clk = ~clk;
    end

    rio_cmd_engine #(.TMO_CYC(20)) DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_bus(bus),
        .o_rdata(o_rdata), .o_link_cmd(link_cmd), .o_link_mode(link_mode),
        .o_link_tx(link_tx), .o_chatter(chatter), .i_link_done(done),
        .i_link_fail(fail), .i_link_rx(rx));

    rio_link_agent agent (.i_ref_clk(clk), .i_rst_n(rst_n), .i_cmd(link_cmd),
        .i_fail_mask(fail_mask), .i_mute_mask(mute_mask), .i_dly(dly),
        .o_done(done), .o_fail(fail), .o_rx(rx));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge clk);
        bus.wr    <= 1'b0;
    endtask : wr

    // expected value is queued here, the monitor compares it
    task automatic rd(input logic [7:0] a, input logic c, input logic [31:0] e,
                      output logic [31:0] v);
        @(posedge clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        chk      <= c;
        if (c) exp_q.push_back(e);
        @(posedge clk);
        bus.rd   <= 1'b0;
        chk      <= 1'b0;
        @(negedge clk);
        v = o_rdata;
    endtask : rd

    // poll for zero under a bound; a hang counts as a mismatch
    task automatic poll;
        logic [31:0] v;
        int          n;
        n = 0;
        do begin
            rd(`ADDR_CMD, 1'b0, 32'h0, v);
            n++;
        end while (v !== 32'h0 && n < 100);
        check("cmd_done", v, 32'h0);
    endtask : poll

    task automatic run(input logic [31:0] c);
        wr(`ADDR_CMD, c);
        poll();
    endtask : run

    // read data are due only in the cycle after the strobe
    always @(posedge clk) chk_d <= chk;
    always @(negedge clk) begin
        if (chk_d) check("rdata", o_rdata, exp_q.pop_front());
        if (link_cmd.halt !== 8'h00)
            check("halt", 32'({link_cmd.purge, link_cmd.halt}), halt_q.pop_front());
        if (link_cmd.req !== 8'h00)
            check("req", 32'({link_cmd.op, link_cmd.req}), req_q.pop_front());
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("watchdog expired");
        end_of_test();
    end

    initial begin
        logic [31:0] v;
        logic [7:0]  par [8];
        par = '{`PARAM_ID, `PARAM_PORT_W, `PARAM_REV_MAJ, `PARAM_REV_MIN,
                `PARAM_GP_NONE, `PARAM_GP_NONE, `PARAM_VARIANT, `PARAM_CH_COUNT};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(`ADDR_CMD, 1'b1, 32'h0, v);
        rd(8'h3c, 1'b1, 32'h0, v);
        $display("test reset done");
        // host polls then reads each parameter
        for (int a = 0; a < 8; a++) begin
            run(32'h0000_2000 | 32'(a));
            rd(`ADDR_DATA, 1'b1, {24'h0, par[a]}, v);
        end
        // host loads data, then writes address with both bits
        wr(`ADDR_DATA, 32'h0000_0077);
        run(32'h0000_a001);
        run(32'h0000_2001);
        rd(`ADDR_DATA, 1'b1, {24'h0, par[1]}, v);
        wr(`ADDR_DATA, 32'hffff_ff5a);
        rd(`ADDR_DATA, 1'b1, 32'h0000_005a, v);
        $display("test parameters done");
        for (int c = 0; c < 8; c++) begin
            v = xs();
            wr(8'h40 + 8'(16 * c) + 8'h0c, v);
            @(negedge clk);
            check("mode", {24'h0, link_mode[c]}, {24'h0, v[31:24]});
            for (int k = 0; k < 3; k++) begin
                v = xs();
                wr(8'h40 + 8'(16 * c + 4 * k), v);
                @(negedge clk);
                check("tx", link_tx[c][k], v);
            end
        end
        $display("test channel registers done");
        halt_q.push_back({23'h0, 1'b1, 8'hff});
        run(32'h0000_0800);
        wr(`ADDR_CMD, 32'h8000_0903);
        rd(`ADDR_CMD, 1'b1, 32'h0, v);
        fail_mask <= 8'h02;
        dly <= 4'h6;
        req_q.push_back(32'({rio_pkg::OP_START_NEW, 8'h03}));
        wr(`ADDR_CMD, 32'h0000_0903);
        rd(`ADDR_CMD, 1'b1, 32'h0000_0903, v);
        poll();
        rd(`ADDR_DATA, 1'b1, 32'h0000_0002, v);
        rd(8'h40, 1'b1, 32'ha500_0000, v);
        rd(8'h5c, 1'b1, 32'h0000_a008, v);
        check("chatter", {30'h0, chatter[1:0]}, 32'h1);
        $display("test start done");
        // transfer cycles only on the started channel
        fail_mask <= 8'h00;
        dly <= 4'h1;
        req_q.push_back(32'({rio_pkg::OP_XFER, 8'h01}));
        run(32'h0000_1001);
        rd(`ADDR_DATA, 1'b1, 32'h0, v);
        check("chatter", {31'h0, chatter[0]}, 32'h0);
        fail_mask <= 8'h01;
        req_q.push_back(32'({rio_pkg::OP_XFER, 8'h01}));
        run(32'h0000_1001);
        rd(`ADDR_DATA, 1'b1, 32'h0000_0001, v);
        $display("test transfer done");
        halt_q.push_back({23'h0, 1'b0, 8'h02});
        run(32'h0000_0802);
        rd(8'h4c, 1'b1, 32'h0000_2008, v);
        rd(8'h5c, 1'b1, 32'h0000_8000, v);
        mute_mask <= 8'h10;
        req_q.push_back(32'({rio_pkg::OP_START_KEEP, 8'h10}));
        wr(`ADDR_CMD, 32'h0000_0910);
        wr(`ADDR_CMD, 32'h0000_2001);
        rd(`ADDR_CMD, 1'b1, 32'h0000_0910, v);
        halt_q.push_back({23'h0, 1'b1, 8'hff});
        run(32'h0000_0800);
        mute_mask <= 8'h00;
        req_q.push_back(32'({rio_pkg::OP_SETUP, 8'h01}));
        run(32'h0000_0f01);
        halt_q.push_back({23'h0, 1'b1, 8'hff});
        run(32'h0000_4000);
        @(negedge clk);
        check("queues", 32'(exp_q.size() + halt_q.size() + req_q.size()), 32'h0);
        $display("test stop and abort done");
        end_of_test();
    end
endmodule : remote_io_link_command_engine_bench
